//--- design/fcmm_pkg.sv
// package: register map, field layout, reset values and timing counts of the config bench
package fcmm_pkg;
  // apb byte offsets of the configuration bench
  localparam logic [11:0] OFS_POLARITY   = 12'h000;
  localparam logic [11:0] OFS_IO_COUNT   = 12'h004;
  localparam logic [11:0] OFS_MODE       = 12'h008;
  localparam logic [11:0] OFS_BOOT_WORDS = 12'h00C;
  localparam logic [11:0] OFS_CONTROL    = 12'h010;
  localparam logic [11:0] OFS_STATUS     = 12'h014;
  localparam logic [11:0] OFS_AM_ADDR    = 12'h018;
  localparam logic [11:0] OFS_AM_DATA    = 12'h01C;
  localparam logic [11:0] OFS_PCM_ADDR   = 12'h020;
  localparam logic [11:0] OFS_PCM_LO     = 12'h024;
  localparam logic [11:0] OFS_PCM_HI     = 12'h028;
  // field positions
  localparam int POS_IN_CNT     = 0;
  localparam int POS_OUT_CNT    = 4;
  localparam int POS_AM_MODE    = 0;
  localparam int POS_PULSE_W    = 4;
  localparam int POS_ROLE       = 8;
  localparam int POS_ONLINE     = 0;
  localparam int POS_START      = 1;
  localparam int POS_PULSE_BUSY = 2;
  // polarity bit positions
  localparam int POL_READY      = 0;
  localparam int POL_RD_STROBE  = 1;
  localparam int POL_WAIT       = 2;
  localparam int POL_DATA_STB   = 3;
  localparam int POL_BUSY       = 4;
  localparam int POL_LAST_IN    = 5;
  localparam int POL_START_CONV = 7;
  // reset values
  localparam logic [7:0]  RST_POLARITY   = 8'hFF;
  localparam logic [2:0]  RST_IN_CNT     = 3'h0;
  localparam logic [1:0]  RST_OUT_CNT    = 2'h0;
  localparam logic        RST_AM_MODE    = 1'h0;
  localparam logic [2:0]  RST_PULSE_W    = 3'h0;
  localparam logic        RST_ROLE       = 1'h0;
  localparam logic [11:0] RST_BOOT_WORDS = 12'h000;
  localparam logic [11:0] MAX_BOOT_WORDS = 12'h984; // 2436
  // memory geometry
  localparam int AM_BYTES   = 256;
  localparam int PCM_WORDS  = 256;
  localparam int MICRO_W    = 36;
  localparam int CONSEQ_W   = 8;
  localparam int PCM_W      = MICRO_W + CONSEQ_W;
  // start-conversion widths in master clock periods
  localparam logic [15:0] PW_CODE0 = 16'h0080; // 128
  localparam logic [15:0] PW_CODE1 = 16'h0100; // 256
  localparam logic [15:0] PW_CODE2 = 16'h07F8; // 2040
  localparam logic [15:0] PW_CODE3 = 16'h0FF0; // 4080
  localparam logic [15:0] PW_CODE4 = 16'h1FE0; // 8160
  localparam logic [15:0] PW_CODE5 = 16'h3FC0; // 16320
  localparam logic [15:0] PW_CODE6 = 16'h7D00; // 32000
  localparam logic [15:0] PW_CODE7 = 16'hFFF0; // 65520
  typedef enum logic {FCMM_SLAVE, FCMM_MASTER} fcmm_role_t;
endpackage

//--- design/fcmm_pulse_gen.sv
// start-conversion pulse generator with programmable width
`timescale 1ns/1ps
module fcmm_pulse_gen
  import fcmm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [2:0] width_code,
  output logic            active
);
  import fcmm_pkg::*;

  logic [CNT_W-1:0] remain;

  // decode width code to clock periods
  function automatic logic [CNT_W-1:0] width_of(input logic [2:0] c);
    case (c)
      3'h0:    width_of = CNT_W'(PW_CODE0);
      3'h1:    width_of = CNT_W'(PW_CODE1);
      3'h2:    width_of = CNT_W'(PW_CODE2);
      3'h3:    width_of = CNT_W'(PW_CODE3);
      3'h4:    width_of = CNT_W'(PW_CODE4);
      3'h5:    width_of = CNT_W'(PW_CODE5);
      3'h6:    width_of = CNT_W'(PW_CODE6);
      default: width_of = CNT_W'(PW_CODE7);
    endcase
  endfunction

  // count down the pulse; start ignored while busy
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= '0;
    end else if (remain != '0) begin
      remain <= remain - CNT_W'(1);
    end else if (start) begin
      remain <= width_of(width_code);
    end
  end

  assign active = (remain != '0);
endmodule

//--- design/fcmm_polarity.sv
// applies programmable handshake polarities in on-line phase only
`timescale 1ns/1ps
module fcmm_polarity
  import fcmm_pkg::*;
(
  input  wire logic [7:0] polarity,
  input  wire logic       online,
  input  wire logic [7:0] int_lvl,
  output logic      [7:0] pin_lvl
);
  import fcmm_pkg::*;

  logic [7:0] eff;

  // off-line forces default active-high; bit 6 is not connected
  always_comb begin
    eff     = online ? polarity : RST_POLARITY;
    pin_lvl = int_lvl ^ ~eff;
    pin_lvl[6] = 1'b0;
  end
endmodule

//--- design/fcmm_config_bench.sv
// configuration bench, antecedent and program/consequent memories behind apb
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - antecedent memory is four 64-byte regions or eight 32-byte regions.
// - mode 0 gives eight inputs of eight functions; mode 1 four of sixteen.
// - each four-byte antecedent word describes one membership function of one input.
// - each stored function carries input tag, three bits or two bits wide.
// - program/consequent memory holds 256 words, one per rule.
// - each word has 36-bit microcode and 8-bit consequent selector.
// - polarity bit 0 means active low, 1 active high; default high.
// - bits 0..5 steer ready, read strobe, wait, data strobe, busy, last input.
// - bit 6 does nothing; bit 7 sets start-conversion pulse level.
// - programmed polarities apply only on-line; off-line uses defaults.
// - input count field is inputs minus one, one to eight.
// - output count field is outputs minus one, one to four.
// - a 3-bit code selects start-conversion pulse width.
// - on-line, role bit 1 means master, 0 means slave.
// - 12-bit boot word count, valid 0 to 2436.
// - width codes give 128 to 65520 master clock periods.
module fcmm_config_bench
  import fcmm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  hs_int,
  input  wire logic [7:0]  am_rd_addr,
  output logic      [7:0]  hs_pin,
  output logic      [31:0] am_rd_word,
  output logic      [2:0]  am_rd_tag,
  output logic      [3:0]  am_rd_index,
  output logic      [3:0]  input_count,
  output logic      [2:0]  output_count,
  output logic             role_master,
  output logic             online,
  output logic             start_conv_out
);
  import fcmm_pkg::*;

  logic              rst_meta;
  logic              rst_sync_n;
  logic [7:0]        handshake_polarity;
  logic [2:0]        input_count_minus_one;
  logic [1:0]        output_count_minus_one;
  logic              antecedent_memory_mode;
  logic [2:0]        start_pulse_width;
  logic              online_role_select;
  logic [11:0]       boot_word_count;
  logic [7:0]        am_ptr;
  logic [7:0]        pcm_ptr;
  logic [MICRO_W-1:0] pcm_micro [PCM_WORDS];
  logic [CONSEQ_W-1:0] pcm_conseq [PCM_WORDS];
  logic [7:0]        am_mem [AM_BYTES];
  logic              start_pulse;
  logic              pulse_busy;
  logic              wr_en;
  logic              rd_en;
  logic              cfg_open;
  logic              mapped;
  logic [31:0]       next_prdata;
  logic [7:0]        hs_lvl;

  // reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // apb access phase; zero wait states
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & penable & ~pwrite;
  assign cfg_open = ~online; // writes other than control land only off-line

  // address decode used by error answer only; read mux has its own case
  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      OFS_POLARITY, OFS_IO_COUNT, OFS_MODE, OFS_BOOT_WORDS, OFS_CONTROL,
      OFS_STATUS, OFS_AM_ADDR, OFS_AM_DATA, OFS_PCM_ADDR, OFS_PCM_LO,
      OFS_PCM_HI: is_mapped = 1'b1;
      default:    is_mapped = 1'b0;
    endcase
  endfunction

  assign mapped = is_mapped(paddr);

  // unmapped access, or config write while on-line, answers with error
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      if (!mapped) begin
        pslverr = 1'b1;
      end else if (pwrite && online && paddr != OFS_CONTROL) begin
        pslverr = 1'b1;
      end
    end
  end

  // configuration fields
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      handshake_polarity     <= RST_POLARITY;
      input_count_minus_one  <= RST_IN_CNT;
      output_count_minus_one <= RST_OUT_CNT;
      antecedent_memory_mode <= RST_AM_MODE;
      start_pulse_width      <= RST_PULSE_W;
      online_role_select     <= RST_ROLE;
      boot_word_count        <= RST_BOOT_WORDS;
    end else if (wr_en && cfg_open) begin
      case (paddr)
        OFS_POLARITY: begin
          handshake_polarity <= pwdata[7:0];
        end
        OFS_IO_COUNT: begin
          input_count_minus_one  <= pwdata[POS_IN_CNT+:3];
          output_count_minus_one <= pwdata[POS_OUT_CNT+:2];
        end
        OFS_MODE: begin
          antecedent_memory_mode <= pwdata[POS_AM_MODE];
          start_pulse_width      <= pwdata[POS_PULSE_W+:3];
          online_role_select     <= pwdata[POS_ROLE];
        end
        OFS_BOOT_WORDS: begin
          // values above the limit saturate to it
          if (pwdata[11:0] > MAX_BOOT_WORDS) begin
            boot_word_count <= MAX_BOOT_WORDS;
          end else begin
            boot_word_count <= pwdata[11:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // phase control and start request
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      online      <= 1'b0;
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      if (wr_en && paddr == OFS_CONTROL) begin
        online      <= pwdata[POS_ONLINE];
        start_pulse <= pwdata[POS_START] & pwdata[POS_ONLINE];
      end
    end
  end

  // memory pointers, auto-increment off-line on antecedent data access and on program/consequent high-word access
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      am_ptr  <= 8'h00;
      pcm_ptr <= 8'h00;
    end else if ((wr_en || rd_en) && cfg_open) begin
      if (pwrite && paddr == OFS_AM_ADDR) begin
        am_ptr <= {pwdata[7:2], 2'b00}; // word aligned
      end else if (paddr == OFS_AM_DATA) begin
        am_ptr <= am_ptr + 8'h04;
      end
      if (pwrite && paddr == OFS_PCM_ADDR) begin
        pcm_ptr <= pwdata[7:0];
      end else if (paddr == OFS_PCM_HI) begin
        pcm_ptr <= pcm_ptr + 8'h01;
      end
    end
  end

  // antecedent memory: one function per four-byte word
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_am_lane
      always_ff @(posedge mclk) begin
        if (wr_en && cfg_open && paddr == OFS_AM_DATA) begin
          am_mem[am_ptr + 8'(g)] <= pwdata[8*g+:8];
        end
      end
    end
  endgenerate

  // program/consequent memory, one word per rule
  always_ff @(posedge mclk) begin
    if (wr_en && cfg_open && paddr == OFS_PCM_LO) begin
      pcm_micro[pcm_ptr][31:0] <= pwdata;
    end
    if (wr_en && cfg_open && paddr == OFS_PCM_HI) begin
      pcm_micro[pcm_ptr][MICRO_W-1:32] <= pwdata[3:0];
      pcm_conseq[pcm_ptr]              <= pwdata[15:8];
    end
  end

  // read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      OFS_POLARITY:   next_prdata[7:0] = handshake_polarity;
      OFS_IO_COUNT: begin
        next_prdata[POS_IN_CNT+:3]  = input_count_minus_one;
        next_prdata[POS_OUT_CNT+:2] = output_count_minus_one;
      end
      OFS_MODE: begin
        next_prdata[POS_AM_MODE]   = antecedent_memory_mode;
        next_prdata[POS_PULSE_W+:3] = start_pulse_width;
        next_prdata[POS_ROLE]      = online_role_select;
      end
      OFS_BOOT_WORDS: next_prdata[11:0] = boot_word_count;
      OFS_CONTROL:    next_prdata[POS_ONLINE] = online;
      OFS_STATUS: begin
        next_prdata[POS_ONLINE]     = online;
        next_prdata[POS_PULSE_BUSY] = pulse_busy;
      end
      OFS_AM_ADDR:  next_prdata[7:0] = am_ptr;
      OFS_AM_DATA:  next_prdata = {am_mem[am_ptr + 8'h03], am_mem[am_ptr + 8'h02],
                                   am_mem[am_ptr + 8'h01], am_mem[am_ptr]};
      OFS_PCM_ADDR: next_prdata[7:0] = pcm_ptr;
      OFS_PCM_LO:   next_prdata = pcm_micro[pcm_ptr][31:0];
      OFS_PCM_HI: begin
        next_prdata[3:0]  = pcm_micro[pcm_ptr][MICRO_W-1:32];
        next_prdata[15:8] = pcm_conseq[pcm_ptr];
      end
      default:      next_prdata = 32'h0000_0000;
    endcase
  end

  // read data captured at setup so it stands registered in access phase
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // datapath view of antecedent memory: region split by mode
  always_comb begin
    am_rd_word = {am_mem[{am_rd_addr[7:2], 2'b11}], am_mem[{am_rd_addr[7:2], 2'b10}],
                  am_mem[{am_rd_addr[7:2], 2'b01}], am_mem[{am_rd_addr[7:2], 2'b00}]};
    if (antecedent_memory_mode) begin
      am_rd_tag   = {1'b0, am_rd_addr[7:6]}; // four 64-byte regions
      am_rd_index = am_rd_addr[5:2]; // sixteen functions
    end else begin
      am_rd_tag   = am_rd_addr[7:5]; // eight 32-byte regions
      am_rd_index = {1'b0, am_rd_addr[4:2]}; // eight functions
    end
  end

  // counts as plain numbers
  assign input_count  = {1'b0, input_count_minus_one} + 4'h1;
  assign output_count = {1'b0, output_count_minus_one} + 3'h1;
  assign role_master  = online & (online_role_select == 1'b1);

  fcmm_pulse_gen #(
    .CNT_W(16)
  ) u_pulse (
    .mclk       (mclk),
    .rst_n      (rst_sync_n),
    .start      (start_pulse),
    .width_code (start_pulse_width),
    .active     (pulse_busy)
  );

  // internal active-high handshakes, start conversion on bit 7
  always_comb begin
    hs_lvl = hs_int;
    hs_lvl[POL_START_CONV] = pulse_busy & online;
  end

  fcmm_polarity u_pol (
    .polarity (handshake_polarity),
    .online   (online),
    .int_lvl  (hs_lvl),
    .pin_lvl  (hs_pin)
  );

  assign start_conv_out = hs_pin[POL_START_CONV];
endmodule

//--- verif/fcmm_asserts.sv
// checker: port-level properties of the configuration bench
`timescale 1ns/1ps
module fcmm_asserts
  import fcmm_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic [7:0]  hs_int,
  input wire logic [7:0]  hs_pin,
  input wire logic [3:0]  input_count,
  input wire logic [2:0]  output_count,
  input wire logic        role_master,
  input wire logic        online,
  input wire logic        start_conv_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // access phase of an apb transfer
  wire logic acc = psel && penable;
  chk_offline_levels: assert property (!online |-> hs_pin[5:0] == hs_int[5:0])
    else $error("handshake level altered off-line");
  chk_spare_bit: assert property (hs_pin[6] == 1'b0)
    else $error("spare polarity bit reached a pin");
  chk_start_pin: assert property (!online |-> start_conv_out == 1'b0)
    else $error("start output active off-line");
  chk_role_offline: assert property (!online |-> !role_master)
    else $error("master role shown off-line");
  chk_count_write: assert property (acc && pwrite && !online && paddr == OFS_IO_COUNT |=>
    input_count == $past(pwdata[2:0]) + 4'h1 && output_count == $past(pwdata[5:4]) + 3'h1)
    else $error("count write not applied as minus one");
  chk_online_hold: assert property (acc && pwrite && online && paddr == OFS_IO_COUNT
    |-> pslverr ##1 $stable(input_count))
    else $error("count changed while on-line");
  chk_unmapped_err: assert property (acc && paddr > OFS_PCM_HI |-> pslverr)
    else $error("unmapped access not refused");
  chk_count_range: assert property (input_count inside {[4'h1:4'h8]}
    && output_count inside {[3'h1:3'h4]})
    else $error("count out of range");
  cover property (acc && pwrite && online);
  cover property (acc && pslverr);
  cover property ($fell(start_conv_out));
endmodule

//--- verif/fcmm_host.sv
// host model: apb master issuing register transfers
`timescale 1ns/1ps
module fcmm_host (
  input  wire logic        mclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // one transfer; an edge passes first so back-to-back calls never clash
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // wait for the answer; only the bench watchdog ends a hung wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

//--- verif/testbench.sv
// top-level bench for the configuration bench block
`timescale 1ns/1ps
module testbench;
  import fcmm_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, psel, penable, pwrite, pready, pslverr, er;
  logic        role_master, online, start_conv_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, am_rd_word, rd;
  logic [7:0]  hs_int = 8'h00, am_rd_addr = 8'h00, hs_pin;
  logic [2:0]  am_rd_tag, output_count;
  logic [3:0]  am_rd_index, input_count;
  int          fails = 0, n_checks = 0;
  always #5 mclk = ~mclk;
  fcmm_host host (.mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  fcmm_config_bench dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hs_int(hs_int), .am_rd_addr(am_rd_addr), .hs_pin(hs_pin),
    .am_rd_word(am_rd_word), .am_rd_tag(am_rd_tag), .am_rd_index(am_rd_index),
    .input_count(input_count), .output_count(output_count), .role_master(role_master),
    .online(online), .start_conv_out(start_conv_out));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask
  task automatic t_counts;
    rdc(OFS_POLARITY, 32'hFF);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_IO_COUNT, 32'((c % 4) << 4 | c));
      @(negedge mclk);
      chk(32'(input_count), c + 1);
      chk(32'(output_count), c % 4 + 1);
    end
    wr(OFS_BOOT_WORDS, 32'd2436);
    rdc(OFS_BOOT_WORDS, 32'd2436);
    wr(OFS_BOOT_WORDS, 32'hFFF);
    rdc(OFS_BOOT_WORDS, 32'd2436);
  endtask
  // store one function word, read it back and through the datapath port
  task automatic t_am(input logic m, input logic [7:0] a, input logic [31:0] d,
                      input logic [2:0] tg, input logic [3:0] ix);
    wr(OFS_MODE, {31'h0, m});
    wr(OFS_AM_ADDR, {24'h0, a});
    wr(OFS_AM_DATA, d);
    am_rd_addr <= a + 8'h2;
    wr(OFS_AM_ADDR, {24'h0, a});
    rdc(OFS_AM_DATA, d);
    @(negedge mclk);
    chk(am_rd_word, d);
    chk(32'(am_rd_tag), 32'(tg));
    chk(32'(am_rd_index), 32'(ix));
  endtask
  task automatic t_pcm;
    wr(OFS_PCM_ADDR, 32'hFF);
    wr(OFS_PCM_LO, 32'h13579BDF);
    wr(OFS_PCM_HI, 32'h5C0A);
    wr(OFS_PCM_ADDR, 32'hFF);
    rdc(OFS_PCM_LO, 32'h13579BDF);
    rdc(OFS_PCM_HI, 32'h5C0A);
  endtask
  // go on-line with a mode word and polarity, then time one start pulse
  task automatic t_pulse(input logic [31:0] mode, input logic [7:0] pol, input int w);
    int n;
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_POLARITY, {24'h0, pol});
    wr(OFS_MODE, mode);
    wr(OFS_CONTROL, 32'h1);
    @(negedge mclk);
    chk(32'(role_master), 32'(mode[8]));
    chk(32'(start_conv_out), {31'h0, ~pol[7]});
    wr(OFS_CONTROL, 32'h3);
    n = 0;
    for (int k = 0; k < 20 && start_conv_out !== pol[7]; k++) @(negedge mclk);
    while (start_conv_out === pol[7] && n < 1000) begin
      n++;
      @(negedge mclk);
    end
    chk(n, w);
    rdc(OFS_STATUS, 32'h1);
  endtask
  task automatic t_online;
    wr(OFS_POLARITY, 32'h35);
    hs_int <= 8'hC9;
    @(negedge mclk);
    chk(32'(hs_pin), 32'h09);
    t_pulse(32'h100, 8'h35, 128);
    chk(32'(hs_pin), 32'h83);
    host.xfer(1'b1, OFS_IO_COUNT, 32'h0, rd, er);
    chk(32'(er), 32'h1);
    @(negedge mclk);
    chk(32'(input_count), 32'h8);
    host.xfer(1'b0, 12'h02C, 32'h0, rd, er);
    chk(32'(er), 32'h1);
    t_pulse(32'h010, 8'hB5, 256);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence: reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk(32'(input_count), 32'h1);
    t_counts;
    t_am(1'b0, 8'hE4, 32'hA1B2C3D4, 3'h7, 4'h1);
    t_am(1'b1, 8'hD8, 32'h5A6B7C8D, 3'h3, 4'h6);
    t_pcm;
    t_online;
    complete_run;
  end
  // watchdog against a hung handshake
  initial begin
    #500us;
    fails++;
    complete_run;
  end
endmodule
bind fcmm_config_bench fcmm_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .hs_int(hs_int), .hs_pin(hs_pin), .input_count(input_count),
  .output_count(output_count), .role_master(role_master), .online(online),
  .start_conv_out(start_conv_out));
